// [bench/link_partner_model.sv]
// Purpose: far-side link partner for the l1 request handshake
// Assumes: same clock as the device, outputs change just after the edge
// Notes:   answers each request once, accepting or refusing on command
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input  wire logic       hclk,       // clock
   input  wire logic       hresetn,    // reset, active low
   input  wire logic       l1_request, // device asks for l1
   input  wire logic       refuse,     // bench wants a refusal
   input  wire logic [3:0] delay,      // cycles before answering
   output var  logic       l1_ack,     // accept pulse
   output var  logic       l1_nak      // refuse pulse
);
   int cnt;
   // wait, answer once, forget the request when it drops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt    <= 0;
         l1_ack <= 1'b0;
         l1_nak <= 1'b0;
      end else begin
         l1_ack <= 1'b0;
         l1_nak <= 1'b0;
         if (!l1_request) begin
            cnt <= 0;
         end else if (cnt == delay) begin
            l1_ack <= !refuse;
            l1_nak <= refuse;
            cnt    <= cnt + 1;
         end else if (cnt < delay) begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : link_partner_model
`default_nettype wire

// [bench/switch_port_link_manager_tb_top.sv]
// Purpose: self-checking bench of the switch port link manager
// Assumes: short hold and expander periods; partner answers l1 requests
// Notes:   expectations come from a small integer model in the bench
`timescale 1ns/1ps
`default_nettype none
module switch_port_link_manager_tb_top;
   import link_mgr_pkg::*;
   localparam int HOLD = 40;
   localparam int TICK = 8;
   logic                    hclk, hresetn, hsel, hwrite, fr_n, spl_v, toff, mpo, refuse, e;
   logic [31:0]             haddr, hwdata, r, d;
   logic [1:0]              htrans;
   logic [2:0]              hsize;
   logic [15:0]             spl_p;
   logic [3:0]              up, m;
   port_in_type [3:0]       pin;
   ltssm_type               s[4];
   wire logic               hready, hresp, l1r, l1a, l1n, tblk;
   wire logic [31:0]        hrdata;
   wire logic [3:0]         lun, actn;
   wire port_out_type [3:0] pout;
   int                      err_count, comparisons, ev[5][4], ex[5][4];
   int                      seed = 7;

   switch_port_link_manager #(.ACT_HOLD_CYC(HOLD), .EXP_PERIOD_CYC(TICK)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fundamental_reset_n(fr_n),
      .port_in(pin), .port_out(pout), .spl_rx_valid(spl_v), .spl_rx_payload(spl_p),
      .turn_off_ack(toff), .main_power_off(mpo), .l1_ack(l1a), .l1_nak(l1n),
      .l1_request(l1r), .traffic_block(tblk), .port_link_up_n(lun), .port_activity_n(actn));
   link_partner_model partner (.hclk(hclk), .hresetn(hresetn), .l1_request(l1r),
      .refuse(refuse), .delay(4'h2), .l1_ack(l1a), .l1_nak(l1n));

   // clock and watchdog
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      #80000;
      err_count++;
      conclude();
   end
   // count one-cycle pulses per port
   always @(posedge hclk) begin
      for (int i = 0; i < 4; i++) begin
         ev[0][i] += pout[i].retrain_recovery;
         ev[1][i] += pout[i].retrain_detect;
         ev[2][i] += pout[i].send_spl;
         ev[3][i] += pout[i].fc_advertise;
         ev[4][i] += pout[i].discard_queue;
      end
   end

   task automatic conclude();
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // one single transfer, held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      haddr  <= {24'h00_0000, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
      bus(1'b0, a, 32'h0000_0000);
      chk(r & mk, x);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic till(input logic v);
      int n;
      for (n = 0; n < 20 && l1r !== v; n++) @(posedge hclk);
      chk(l1r, v);
   endtask : till
   function automatic logic live(input ltssm_type t);
      return t inside {LT_L0, LT_L0S, LT_L1, LT_RECOVERY};
   endfunction : live
   function automatic logic idle(input int i);
      return !(pin[i].tlp_pending && pin[i].credits_ok) && !pin[i].dllp_pending;
   endfunction : idle
   // set link states, track expected edges, check status after two ticks
   task automatic lt(input ltssm_type v[4]);
      for (int i = 0; i < 4; i++) begin
         pin[i].ltssm <= v[i];
         if (live(v[i]) && !up[i]) begin
            ex[3][i]++;
            if (i > 0) ex[2][i]++;
         end
         if (!live(v[i]) && up[i]) ex[4][i]++;
         up[i] = live(v[i]);
      end
      cyc(2 * TICK + 3);
      chk(lun, {28'h000_0000, ~up});
      for (int i = 0; i < 4; i++) chk(pout[i].ur_target, !up[i]);
   endtask : lt

   initial begin
      {hsel, hwrite, htrans, hsize, haddr, hwdata, d} = '0;
      {spl_v, spl_p, toff, mpo, refuse} = '0;
      pin     = '0;
      fr_n    = 1'b1;
      up      = 4'h0;
      hresetn = 1'b0;
      cyc(16);
      hresetn <= 1'b1;
      cyc(1);
      // reset values, locked width write, retrain bits
      rd(8'h04, 32'h0000_0010, '1);
      rd(8'h1C, 32'h0000_0100, '1);
      rd(8'h10, 32'h0000_0000, '1);
      rd(8'h30, 32'h0000_0000, '1);
      bus(1'b1, 8'h04, 32'h0000_0020);
      bus(1'b1, 8'h08, 32'h0000_000F);
      rd(8'h04, 32'h0000_0010, '1);
      bus(1'b1, 8'h00, 32'h0000_0001);
      bus(1'b1, 8'h04, 32'h0000_0020);
      bus(1'b1, 8'h08, 32'h0000_0001);
      m = 4'($random(seed));
      bus(1'b1, 8'h0C, {28'h000_0000, m});
      rd(8'h04, 32'h0000_0020, '1);
      rd(8'h08, 32'h0000_0000, '1);
      rd(8'h0C, 32'h0000_0000, '1);
      rd(8'h10, 32'h0000_0000, '1);
      ex[0] = '{1, 1, 1, 1};
      for (int i = 0; i < 4; i++) ex[1][i] = m[i];
      // polarity seen on one lane only
      for (int i = 0; i < 4; i++) begin
         pin[i].ltssm       <= LT_CONFIG;
         pin[i].ts_valid    <= 1'b1;
         pin[i].ts_inverted <= (i == 2);
      end
      cyc(3);
      for (int i = 0; i < 4; i++) begin
         chk(pout[i].rx_invert, i == 2);
         chk(pout[i].tx_invert, 1'b0);
         pin[i].ts_valid <= 1'b0;
      end
      // random link states
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 4; i++) s[i] = ltssm_type'(4'({$random(seed)} % 7));
         lt(s);
      end
      // activity: plain tlp on port 2, vendor message on port 3
      pin[2].tlp_event  <= 1'b1;
      pin[3].tlp_event  <= 1'b1;
      pin[3].tlp_vendor <= 1'b1;
      cyc(1);
      pin[2].tlp_event <= 1'b0;
      pin[3].tlp_event <= 1'b0;
      cyc(30);
      chk(actn, 4'hB);
      cyc(30);
      chk(actn, 4'hF);
      // slot power capture and send
      spl_p <= 16'($random(seed));
      spl_v <= 1'b1;
      cyc(1);
      spl_v <= 1'b0;
      cyc(2);
      rd(8'h14, {4'h0, spl_p[9:8], spl_p[7:0], 18'h0_0000}, '1);
      pin[0].tlp_pending <= 1'b1;
      pin[3].in_d3       <= 1'b1;
      lt('{LT_DETECT, LT_DETECT, LT_DETECT, LT_DETECT});
      lt('{LT_L0, LT_L1, LT_DETECT, LT_L0});
      rd(8'h10, 32'h000B_0010, '1);
      d = $random(seed);
      bus(1'b1, 8'h18, d);
      rd(8'h18, d, '1);
      ex[2][1]++;
      ex[2][3]++;
      // transmitter l0s permission
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 4; i++) begin
            {pin[i].rx_l0s, pin[i].tlp_pending, pin[i].credits_ok, pin[i].dllp_pending}
               <= 4'($random(seed));
         end
         cyc(3);
         e = idle(0);
         for (int i = 1; i < 4; i++) if (up[i] && !pin[i].in_d3 && !pin[i].rx_l0s) e = 1'b0;
         chk(pout[0].tx_l0s_allow, e);
         for (int i = 1; i < 4; i++) chk(pout[i].tx_l0s_allow, pin[0].rx_l0s && idle(i));
      end
      for (int i = 0; i < 4; i++) {pin[i].tlp_pending, pin[i].dllp_pending} <= {i == 0, 1'b0};
      // l1 accepted, then refused
      bus(1'b1, 8'h1C, 32'h0000_0006);
      pin[0].tlp_pending <= 1'b0;
      cyc(6);
      chk(l1r, 1'b0);
      till(1'b1);
      till(1'b0);
      rd(8'h20, 32'h0000_0004, 32'h0000_003F);
      pin[0].tlp_pending <= 1'b1;
      refuse             <= 1'b1;
      cyc(3);
      rd(8'h20, 32'h0000_0001, 32'h0000_003F);
      pin[0].tlp_pending <= 1'b0;
      till(1'b1);
      till(1'b0);
      rd(8'h20, 32'h0000_0008, 32'h0000_003F);
      lt('{LT_L0, LT_L0, LT_DETECT, LT_L0});
      chk(l1r, 1'b0);
      // turn-off, l2 and fundamental reset
      pin[0].tlp_pending <= 1'b1;
      cyc(2);
      chk(tblk, 1'b0);
      toff <= 1'b1;
      cyc(1);
      toff <= 1'b0;
      cyc(2);
      chk(tblk, 1'b1);
      rd(8'h20, 32'h0000_0010, 32'h0000_003F);
      mpo <= 1'b1;
      cyc(20);
      rd(8'h20, 32'h0000_0020, 32'h0000_003F);
      mpo  <= 1'b0;
      fr_n <= 1'b0;
      cyc(6);
      fr_n <= 1'b1;
      cyc(3);
      chk(tblk, 1'b0);
      for (int k = 0; k < 5; k++) begin
         for (int i = 0; i < 4; i++) chk(ev[k][i], ex[k][i]);
      end
      conclude();
   end
endmodule : switch_port_link_manager_tb_top
`default_nettype wire

// [design/link_mgr_map.svh]
// Purpose: offsets, fields, resets and timing of the link manager
// Assumes: byte addresses on a 32-bit AHB-Lite bus
// Notes:   definitions only
`ifndef LINK_MGR_MAP_SVH
`define LINK_MGR_MAP_SVH
`define OFS_SWITCH_CTRL  8'h00
`define OFS_LINK_CAP     8'h04
`define OFS_LINK_CTRL    8'h08
`define OFS_PHY_STATE    8'h0C
`define OFS_LINK_STATUS  8'h10
`define OFS_DEV_CAP      8'h14
`define OFS_SLOT_CAP     8'h18
`define OFS_PM_CTRL      8'h1C
`define OFS_PM_STATUS    8'h20
`define WIDTH_LSB        4
`define SCALE_LSB        18
`define VALUE_LSB        26
`define LINKUP_LSB       16
`define MAX_WIDTH_RST    6'h01
`define L1_TIMER_RST     16'h0100
`define NEG_WIDTH_X1     6'h01
`define CLK_MHZ          250
`define ACT_HOLD_MS      200
`define EXP_PERIOD_MS    40
`endif

// [design/link_mgr_pkg.sv]
// Purpose: types shared by the link manager and its bench
// Assumes: four ports, port 0 upstream, ports 1..3 downstream
// Notes:   ltssm codes come from the physical layer
package link_mgr_pkg;
   typedef enum logic [3:0] {
      LT_DETECT = 4'h0, LT_POLLING = 4'h1, LT_CONFIG = 4'h2,
      LT_L0 = 4'h3, LT_L0S = 4'h4, LT_L1 = 4'h5, LT_RECOVERY = 4'h6,
      LT_L2 = 4'h7, LT_OTHER = 4'h8
   } ltssm_type;
   typedef enum logic [5:0] {
      PM_L0 = 6'h01, PM_REQ = 6'h02, PM_L1 = 6'h04,
      PM_L0S = 6'h08, PM_L23 = 6'h10, PM_L2 = 6'h20
   } pm_type;
   typedef struct packed {
      ltssm_type ltssm;     // physical layer state
      logic ts_valid;      // ordered set symbols checked
      logic ts_inverted;   // inversion seen in those symbols
      logic rx_l0s;        // receive lane in l0s
      logic in_d3;         // port in d3
      logic tlp_pending;   // tlp waiting to go out
      logic credits_ok;    // credits for that tlp
      logic dllp_pending;  // dllp waiting to go out
      logic tlp_event;     // tlp sent or received, one cycle
      logic tlp_vendor;    // that tlp is a vendor message
   } port_in_type;
   typedef struct packed {
      logic retrain_recovery; // pulse: go to recovery
      logic retrain_detect;   // pulse: go to detect
      logic rx_invert;        // invert received data
      logic tx_invert;        // always low
      logic tx_l0s_allow;     // transmitter may enter l0s
      logic discard_queue;    // pulse: drop queued tlps
      logic ur_target;        // tlps to here are unsupported
      logic fc_advertise;     // pulse: advertise credits
      logic send_spl;         // pulse: send slot power message
   } port_out_type;
   typedef struct packed {
      logic        hready;
      logic        hresp;
      logic [31:0] hrdata;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic        unlock;
      logic [5:0]  max_w;
      logic [5:0]  train_w;
      logic [5:0]  neg_w;
      logic [31:0] slot_cap;
      logic [15:0] l1_timer;
      logic [7:0]  cap_scale;
      logic [1:0]  cap_value;
      logic [2:0]  frs;
      pm_type      pm;
      logic [15:0] l1_cnt;
      logic        l1_req;
      logic        blk;
      logic [3:0][25:0] act_cnt;
      logic [3:0]  act_lvl;
      logic [23:0] exp_cnt;
      logic [3:0]  up;
      logic [3:0]  up_n;
      logic [3:0]  act_n;
      port_out_type [3:0] po;
   } state_type;
endpackage : link_mgr_pkg

// [design/switch_port_link_manager.sv]
// Purpose: per-port link management of a four-port x1 switch
// Assumes: port inputs are on hclk; fundamental_reset_n is a pin
// Notes:   registers over AHB-Lite, zero wait states
//
// Overview of operation
// - each lane latches its own receive inversion from checked ordered sets
// - transmit data is never inverted
// - upstream trains to one lane and reports that width, or 0 when max width is 0
// - upstream max width writable only when unlocked; used at next training
// - upstream retrain bit acts only when unlocked; goes to recovery
// - downstream retrain bit always acts; goes to recovery
// - full retrain bit of any port sends that link to detect
// - retraining never resets the registers of either end
// - link down drops its queued tlps; tlps toward it are unsupported
// - config access stays open while down; credits advertised on link up
// - slot power message payload copied into captured scale and value
// - downstream sends slot power on slot cap write while up, and link up
// - l2/l3 ready only after turn-off acknowledge; no traffic there
// - l2 left only on fundamental reset
// - upstream l0s needs downstream rx l0s, no sendable tlp, no dllp
// - downstream l0s needs upstream rx l0s, no sendable tlp, no dllp
// - upstream asks l1 after conditions last the entry timer; never downstream
// - partner acknowledges or refuses; enter l1 or l0s accordingly
// - upstream asks l1 only when all live downstream ports are in l1
// - link up shown in l0, l0s, l1 and recovery, else negated
// - activity on non-vendor tlp, held 200 ms for 40 ms expander
`include "link_mgr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module switch_port_link_manager
   import link_mgr_pkg::*;
#(
   parameter int ACT_HOLD_CYC   = `ACT_HOLD_MS * 1000 * `CLK_MHZ,
   parameter int EXP_PERIOD_CYC = `EXP_PERIOD_MS * 1000 * `CLK_MHZ
) (
   input  wire logic                      hclk,                // bus clock
   input  wire logic                      hresetn,             // async reset
   input  wire logic                      hsel,                // slave select
   input  wire logic [31:0]               haddr,               // address
   input  wire logic [1:0]                htrans,              // transfer type
   input  wire logic                      hwrite,              // write
   input  wire logic [2:0]                hsize,               // size
   input  wire logic [31:0]               hwdata,              // write data
   input  wire logic                      hready,              // bus ready
   output      logic                      hreadyout,           // slave ready
   output      logic                      hresp,               // always okay
   output      logic [31:0]               hrdata,              // read data
   input  wire logic                      fundamental_reset_n, // reset pin
   input  wire link_mgr_pkg::port_in_type [3:0] port_in,       // per port
   output      link_mgr_pkg::port_out_type [3:0] port_out,     // per port
   input  wire logic                      spl_rx_valid,        // slot power msg
   input  wire logic [15:0]               spl_rx_payload,      // its bytes 1,0
   input  wire logic                      turn_off_ack,        // turn-off acked
   input  wire logic                      main_power_off,      // aux only
   input  wire logic                      l1_ack,              // partner ack
   input  wire logic                      l1_nak,              // partner refuse
   output      logic                      l1_request,          // ask for l1
   output      logic                      traffic_block,       // no tlp/dllp
   output      logic [3:0]                port_link_up_n,      // expander level
   output      logic [3:0]                port_activity_n      // expander level
);
   import link_mgr_pkg::*;

   state_type s_q;
   state_type s_d;
   logic [3:0] up_now;
   logic [3:0] live;
   logic       l1_cond;
   logic       frs_on;

   function automatic logic is_up(input ltssm_type t);
      is_up = (t == LT_L0) || (t == LT_L0S) || (t == LT_L1)
            || (t == LT_RECOVERY);
   endfunction : is_up

   // link state decode per port
   for (genvar i = 0; i < 4; i++) begin : g_up
      assign up_now[i] = is_up(port_in[i].ltssm);
      assign live[i]   = s_q.up[i] && !port_in[i].in_d3;
   end
   // upstream l1 entry conditions
   assign l1_cond = ((live[3:1] & ~{port_in[3].ltssm == LT_L1,
                    port_in[2].ltssm == LT_L1,
                    port_in[1].ltssm == LT_L1}) == 3'b000)
                    && !port_in[0].tlp_pending && !port_in[0].dllp_pending;
   // reset pin level once second and third stages agree
   assign frs_on  = (s_q.frs[2:1] == 2'b00);

   // next state
   always_comb begin
      logic [31:0] rd;
      rd  = 32'h0000_0000;
      s_d = s_q;
      s_d.frs = {s_q.frs[1:0], fundamental_reset_n};
      for (int i = 0; i < 4; i++) begin
         s_d.po[i].retrain_recovery = 1'b0;
         s_d.po[i].retrain_detect   = 1'b0;
         s_d.po[i].discard_queue    = 1'b0;
         s_d.po[i].fc_advertise     = 1'b0;
         s_d.po[i].send_spl         = 1'b0;
         s_d.po[i].tx_invert        = 1'b0;
      end
      s_d.l1_req = 1'b0;
      // register writes, data phase
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            `OFS_SWITCH_CTRL: begin
               s_d.unlock = hwdata[0];
            end
            `OFS_LINK_CAP: begin
               if (s_q.unlock) begin
                  s_d.max_w = hwdata[`WIDTH_LSB +: 6];
               end
            end
            `OFS_LINK_CTRL: begin
               s_d.po[0].retrain_recovery = hwdata[0] && s_q.unlock;
               for (int i = 1; i < 4; i++) begin
                  s_d.po[i].retrain_recovery = hwdata[i];
               end
            end
            `OFS_PHY_STATE: begin
               for (int i = 0; i < 4; i++) begin
                  s_d.po[i].retrain_detect = hwdata[i];
               end
            end
            `OFS_SLOT_CAP: begin
               s_d.slot_cap = hwdata;
               for (int i = 1; i < 4; i++) begin
                  s_d.po[i].send_spl = s_q.up[i];
               end
            end
            `OFS_PM_CTRL: begin
               s_d.l1_timer = hwdata[15:0];
            end
            default: begin
            end
         endcase
      end
      // address phase: latch write, prepare read data
      if (hsel && hready && htrans[1]) begin
         s_d.wr_pend = hwrite;
         s_d.wr_addr = haddr[7:0];
         case (haddr[7:0])
            `OFS_SWITCH_CTRL: rd[0] = s_q.unlock;
            `OFS_LINK_CAP:    rd[`WIDTH_LSB +: 6] = s_q.max_w;
            `OFS_LINK_STATUS: begin
               rd[`WIDTH_LSB +: 6] = s_q.neg_w;
               rd[`LINKUP_LSB +: 4] = s_q.up;
            end
            `OFS_DEV_CAP: begin
               rd[`SCALE_LSB +: 8] = s_q.cap_scale;
               rd[`VALUE_LSB +: 2] = s_q.cap_value;
            end
            `OFS_SLOT_CAP:    rd = s_q.slot_cap;
            `OFS_PM_CTRL:     rd[15:0] = s_q.l1_timer;
            `OFS_PM_STATUS: begin
               rd[5:0] = s_q.pm;
               for (int i = 0; i < 4; i++) begin
                  rd[8 + i] = s_q.po[i].rx_invert;
               end
            end
            default: rd = 32'h0000_0000;
         endcase
         s_d.hrdata = rd;
      end
      // per-port link tracking
      for (int i = 0; i < 4; i++) begin
         s_d.up[i] = up_now[i];
         // polarity per lane, cleared when training restarts
         if (port_in[i].ltssm == LT_DETECT) begin
            s_d.po[i].rx_invert = 1'b0;
         end else if (port_in[i].ts_valid && port_in[i].ts_inverted
                      && (port_in[i].ltssm == LT_POLLING
                          || port_in[i].ltssm == LT_CONFIG)) begin
            s_d.po[i].rx_invert = 1'b1;
         end
         // down: drop queue, refuse traffic; up: credits
         s_d.po[i].discard_queue = s_q.up[i] && !up_now[i];
         s_d.po[i].ur_target     = !up_now[i];
         s_d.po[i].fc_advertise  = !s_q.up[i] && up_now[i];
         if (i > 0 && !s_q.up[i] && up_now[i]) begin
            s_d.po[i].send_spl = 1'b1;
         end
         // activity stretch
         if (port_in[i].tlp_event && !port_in[i].tlp_vendor) begin
            s_d.act_cnt[i] = 26'(ACT_HOLD_CYC);
            s_d.act_lvl[i] = 1'b1;
         end else if (s_q.act_cnt[i] != 26'h000_0000) begin
            s_d.act_cnt[i] = s_q.act_cnt[i] - 26'h000_0001;
            s_d.act_lvl[i] = (s_q.act_cnt[i] != 26'h000_0001);
         end
      end
      // downstream l0s from upstream rx lane state
      for (int i = 1; i < 4; i++) begin
         s_d.po[i].tx_l0s_allow = port_in[0].rx_l0s
            && !(port_in[i].tlp_pending && port_in[i].credits_ok)
            && !port_in[i].dllp_pending;
      end
      // upstream l0s from live downstream rx lanes
      s_d.po[0].tx_l0s_allow = 1'b1;
      for (int i = 1; i < 4; i++) begin
         if (live[i] && !port_in[i].rx_l0s) begin
            s_d.po[0].tx_l0s_allow = 1'b0;
         end
      end
      if ((port_in[0].tlp_pending && port_in[0].credits_ok)
          || port_in[0].dllp_pending) begin
         s_d.po[0].tx_l0s_allow = 1'b0;
      end
      // width latched at training start, reported at training end
      if (port_in[0].ltssm == LT_DETECT) begin
         s_d.train_w = s_q.max_w;
      end
      if (port_in[0].ltssm == LT_L0 && !s_q.up[0]) begin
         s_d.neg_w = (s_q.train_w == 6'h00) ? 6'h00 : `NEG_WIDTH_X1;
      end
      // captured slot power on upstream
      if (spl_rx_valid) begin
         s_d.cap_scale = spl_rx_payload[7:0];
         s_d.cap_value = spl_rx_payload[9:8];
      end
      // expander update period
      if (s_q.exp_cnt >= 24'(EXP_PERIOD_CYC - 1)) begin
         s_d.exp_cnt = 24'h00_0000;
         s_d.up_n    = ~s_q.up;
         s_d.act_n   = ~s_q.act_lvl;
      end else begin
         s_d.exp_cnt = s_q.exp_cnt + 24'h00_0001;
      end
      // upstream power state
      case (s_q.pm)
         PM_L0, PM_L0S: begin
            if (turn_off_ack) begin
               s_d.pm = PM_L23;
            end else if (!up_now[0] || !l1_cond) begin
               s_d.l1_cnt = 16'h0000;
               if (s_q.pm == PM_L0S && (port_in[0].tlp_pending
                                        || port_in[0].dllp_pending)) begin
                  s_d.pm = PM_L0;
               end
            end else if (s_q.l1_cnt >= s_q.l1_timer) begin
               s_d.pm     = PM_REQ;
               s_d.l1_req = 1'b1;
               s_d.l1_cnt = 16'h0000;
            end else begin
               s_d.l1_cnt = s_q.l1_cnt + 16'h0001;
            end
         end
         PM_REQ: begin
            s_d.l1_req = !(l1_ack || l1_nak);
            if (l1_ack) begin
               s_d.pm = PM_L1;
            end else if (l1_nak) begin
               s_d.pm = PM_L0S;
            end
         end
         PM_L1: begin
            if (turn_off_ack) begin
               s_d.pm = PM_L23;
            end else if (port_in[0].tlp_pending || port_in[0].dllp_pending
                         || !l1_cond) begin
               s_d.pm = PM_L0;
            end
         end
         PM_L23: begin
            if (main_power_off) begin
               s_d.pm = PM_L2;
            end
         end
         PM_L2: begin
            if (frs_on) begin
               s_d.pm = PM_L0;
            end
         end
         default: s_d.pm = PM_L0;
      endcase
      // traffic stops in l2/l3 ready and l2, registered with the state
      s_d.blk = (s_d.pm == PM_L23) || (s_d.pm == PM_L2);
   end

   // one register for all state; retraining never touches it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.hready   <= 1'b1;
         s_q.max_w    <= `MAX_WIDTH_RST;
         s_q.train_w  <= `MAX_WIDTH_RST;
         s_q.l1_timer <= `L1_TIMER_RST;
         s_q.frs      <= 3'h7;
         s_q.pm       <= PM_L0;
         s_q.up_n     <= 4'hF;
         s_q.act_n    <= 4'hF;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout       = s_q.hready;
   assign hresp           = s_q.hresp;
   assign hrdata          = s_q.hrdata;
   assign port_out        = s_q.po;
   assign l1_request      = s_q.l1_req;
   assign traffic_block   = s_q.blk;
   assign port_link_up_n  = s_q.up_n;
   assign port_activity_n = s_q.act_n;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_ctrl_wr;
      s_q.wr_pend && s_q.wr_addr == `OFS_LINK_CTRL;
   endsequence
   sequence s_tlp_seen(int p);
      port_in[p].tlp_event && !port_in[p].tlp_vendor;
   endsequence

   a_up_retrain_lock: assert property (
      s_ctrl_wr and (!s_q.unlock) |=> !port_out[0].retrain_recovery)
      else $error("upstream retrain while locked");
   a_down_retrain_go: assert property (
      s_ctrl_wr and (hwdata[2]) |=> port_out[2].retrain_recovery)
      else $error("downstream retrain lost");
   a_full_retrain_go: assert property (
      s_q.wr_pend && s_q.wr_addr == `OFS_PHY_STATE && hwdata[1]
      |=> port_out[1].retrain_detect)
      else $error("full retrain lost");
   a_tx_never_inv: assert property (
      port_out[0].tx_invert == 1'b0)
      else $error("transmit inverted");
   a_link_up_map: assert property (
      ##1 s_q.up[3] == $past(port_in[3].ltssm == LT_L0
         || port_in[3].ltssm == LT_L0S || port_in[3].ltssm == LT_L1
         || port_in[3].ltssm == LT_RECOVERY))
      else $error("link up does not follow ltssm");
   a_activity_hold: assert property (
      s_tlp_seen(2) |=> s_q.act_lvl[2] [*8])
      else $error("activity not held");
   a_discard_down: assert property (
      s_q.up[2] && !up_now[2] |=> port_out[2].discard_queue
         && port_out[2].ur_target)
      else $error("down link not flushed");
   a_spl_capture: assert property (
      spl_rx_valid |=> s_q.cap_scale == $past(spl_rx_payload[7:0])
         && s_q.cap_value == $past(spl_rx_payload[9:8]))
      else $error("slot power not captured");
   a_l2_exit_only: assert property (
      s_q.pm == PM_L2 && !frs_on |=> s_q.pm == PM_L2)
      else $error("l2 left without reset");
   a_l1_req_cause: assert property (
      $rose(l1_request) |-> $past(l1_cond) && $past(up_now[0]))
      else $error("l1 asked without conditions");
   a_l1_answer: assert property (
      s_q.pm == PM_REQ && l1_nak && !l1_ack |=> s_q.pm == PM_L0S)
      else $error("refused l1 not in l0s");
   // power state entry, l0s gating and slot power on link up
   a_turnoff_entry: assert property (
      s_q.pm != PM_L23 && !turn_off_ack |=> s_q.pm != PM_L23)
      else $error("l2/l3 ready without turn-off acknowledge");
   a_block_l23: assert property (
      s_q.pm == PM_L23 || s_q.pm == PM_L2 |-> traffic_block)
      else $error("traffic not blocked in l2/l3 ready");
   a_tx_l0s_gate: assert property (
      !port_in[0].rx_l0s |=> !port_out[1].tx_l0s_allow)
      else $error("downstream l0s without upstream rx l0s");
   a_spl_link_up: assert property (
      !s_q.up[1] && up_now[1] |=> port_out[1].send_spl)
      else $error("slot power not sent on link up");
endmodule : switch_port_link_manager
`default_nettype wire
